//--- lhif_chk.sv
`timescale 1ns/10ps
`include "lhif_map.vh"
// ----------------------------------------
// pin-level checker
// ----------------------------------------
module lhif_chk (
	// clock, reset, straps
	input wire core_clk,
	input wire rstn,
	input wire [2:0] interface_select_straps,
	input wire booster_default_strap,
	input wire bias_default_strap,
	input wire clock_source_pin,
	// host pins
	input wire chip_select_n,
	input wire rd_n_or_enable,
	input wire wr_n_or_rw,
	input wire [7:0] data_bus_out,
	input wire [7:0] data_bus_oe,
	// core side
	input wire [7:0] read_data,
	input wire write_valid,
	input wire booster_5x,
	input wire bias_1_9,
	input wire use_internal_osc
);
	wire [2:0] m = interface_select_straps;
	wire sep = !chip_select_n && m == `LHIF_MODE_PAR_RW;
	wire en = !chip_select_n && m == `LHIF_MODE_PAR_EN;
	wire i2c = m == `LHIF_MODE_I2C;
	wire e = rd_n_or_enable;
	wire w = wr_n_or_rw;
	wire rd = (sep && !e) || (en && e && w);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence s_sep_wr;
		sep && !w ##1 sep && w;
	endsequence
	sequence s_en_wr;
		en && e && !w ##1 en && !e && !w;
	endsequence
	property p_sep_wr;
		s_sep_wr |-> ##[1:3] write_valid;
	endproperty
	a_sep_wr: assert property (p_sep_wr) else $error("sep write lost");
	property p_en_wr;
		s_en_wr |-> ##[1:3] write_valid;
	endproperty
	a_en_wr: assert property (p_en_wr) else $error("en write lost");
	property p_pulse;
		write_valid |=> !write_valid;
	endproperty
	a_pulse: assert property (p_pulse) else $error("write pulse long");
	property p_rd;
		rd |=> data_bus_oe == 8'hFF && data_bus_out == $past(read_data);
	endproperty
	a_rd: assert property (p_rd) else $error("read not driven");
	property p_nodrv;
		!$past(rd) && !i2c |-> data_bus_oe == 8'h00;
	endproperty
	a_nodrv: assert property (p_nodrv) else $error("bus driven");
	property p_ignore;
		(chip_select_n && !i2c) [*4] |-> !write_valid;
	endproperty
	a_ignore: assert property (p_ignore) else $error("write unselected");
	property p_i2c;
		i2c |-> (data_bus_oe & 8'hF3) == 8'h00
			&& (data_bus_out & data_bus_oe) == 8'h00;
	endproperty
	a_i2c: assert property (p_i2c) else $error("i2c drive wrong");
	property p_strap;
		rstn && $past(rstn) |-> booster_5x == booster_default_strap
			&& bias_1_9 == bias_default_strap
			&& use_internal_osc == clock_source_pin;
	endproperty
	a_strap: assert property (p_strap) else $error("strap value");
endmodule
bind lhif_host_front lhif_chk chk_u (
	.core_clk(core_clk), .rstn(rstn),
	.interface_select_straps(interface_select_straps),
	.booster_default_strap(booster_default_strap),
	.bias_default_strap(bias_default_strap),
	.clock_source_pin(clock_source_pin), .chip_select_n(chip_select_n),
	.rd_n_or_enable(rd_n_or_enable), .wr_n_or_rw(wr_n_or_rw),
	.data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
	.read_data(read_data), .write_valid(write_valid),
	.booster_5x(booster_5x), .bias_1_9(bias_1_9),
	.use_internal_osc(use_internal_osc)
);

//--- lhif_host_front.v
// What this block does
// - strap codes map to five link modes
// - deselect clears serial shift and counter
// - parallel and 4-wire spi: select high data, low command
// - separate-strobe write latched on rising edge
// - enable mode: high read, low write
// - enable mode write latched on falling edge
// - drive bus during read, ack pins during i2c ack
// - spi rising sclk, msb first, byte on eighth
// - i2c address low bits from top pins
// - i2c data in pin, ack on outputs
// - clock pin high selects internal oscillator
// - booster default strap: low 4x, high 5x
// - bias default strap: low 1/7, high 1/9
`timescale 1ns/10ps
`include "lhif_map.vh"
module lhif_host_front (
	// clock and reset
	input wire core_clk,
	input wire rstn,
	// straps
	input wire [2:0] interface_select_straps,
	input wire booster_default_strap,
	input wire bias_default_strap,
	input wire clock_source_pin,
	// host control pins
	input wire chip_select_n,
	input wire data_command_select,
	input wire rd_n_or_enable,
	input wire wr_n_or_rw,
	// data bus pins
	input wire [7:0] data_bus_in,
	output reg [7:0] data_bus_out,
	output reg [7:0] data_bus_oe,
	// core side
	input wire [7:0] read_data,
	output reg write_valid,
	output reg [7:0] write_data,
	output reg write_is_display,
	output reg read_strobe,
	output reg booster_5x,
	output reg bias_1_9,
	output reg use_internal_osc,
	output reg ext_clock_level
);
	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	function is_mode;
		input [2:0] straps;
		input [2:0] code;
		begin
			is_mode = (straps == code);
		end
	endfunction
	wire m_spi4 = is_mode(interface_select_straps, `LHIF_MODE_SPI4);
	wire m_spi3 = is_mode(interface_select_straps, `LHIF_MODE_SPI3);
	wire m_prw = is_mode(interface_select_straps, `LHIF_MODE_PAR_RW);
	wire m_pen = is_mode(interface_select_straps, `LHIF_MODE_PAR_EN);
	wire m_i2c = is_mode(interface_select_straps, `LHIF_MODE_I2C);
	wire sel = !chip_select_n;
	// ----------------------------------------
	// pin history for edge detection
	// ----------------------------------------
	reg rd_d_reg;
	reg wr_d_reg;
	reg sclk_d_reg;
	reg sda_d_reg;
	always @(posedge core_clk) begin
		if (!rstn) begin
			// follow the pins so no false edge appears after reset
			rd_d_reg <= rd_n_or_enable;
			wr_d_reg <= wr_n_or_rw;
			sclk_d_reg <= data_bus_in[0];
			sda_d_reg <= data_bus_in[1];
		end else begin
			rd_d_reg <= rd_n_or_enable;
			wr_d_reg <= wr_n_or_rw;
			sclk_d_reg <= data_bus_in[0];
			sda_d_reg <= data_bus_in[1];
		end
	end
	wire sclk_rise = data_bus_in[0] && !sclk_d_reg;
	wire wr_rise = wr_n_or_rw && !wr_d_reg;
	wire en_fall = !rd_n_or_enable && rd_d_reg;
	wire prd_fall = !rd_n_or_enable && rd_d_reg;
	wire en_rise = rd_n_or_enable && !rd_d_reg;
	// ----------------------------------------
	// spi receiver
	// ----------------------------------------
	wire spi_active = sel && (m_spi4 || m_spi3);
	wire spi_valid;
	wire [7:0] spi_byte;
	lhif_serial_rx #(.WIDTH(8)) u_spi (
		.core_clk(core_clk),
		.rstn(rstn),
		.active(spi_active),
		.sclk_rise(sclk_rise),
		.sdata(data_bus_in[1]),
		.byte_valid(spi_valid),
		.byte_data(spi_byte)
	);
	// ----------------------------------------
	// i2c slave receiver
	// ----------------------------------------
	localparam I_IDLE = 4'b0001;
	localparam I_ADDR = 4'b0010;
	localparam I_DATA = 4'b0100;
	localparam I_ACK = 4'b1000;
	reg [3:0] i_state_reg;
	reg [7:0] i_shift_reg;
	reg [3:0] i_cnt_reg;
	reg i_ack_reg;
	reg i_addr_ok_reg;
	wire i_sda = data_bus_in[1];
	wire i_scl = data_bus_in[0];
	wire i_scl_fall = !i_scl && sclk_d_reg;
	wire i_start = i_scl && sclk_d_reg && sda_d_reg && !i_sda;
	wire i_stop = i_scl && sclk_d_reg && !sda_d_reg && i_sda;
	wire [7:0] i_byte = {i_shift_reg[6:0], i_sda};
	wire [1:0] sa = {data_bus_in[`LHIF_SA_HI], data_bus_in[`LHIF_SA_LO]};
	reg i_valid;
	always @(posedge core_clk) begin
		if (!rstn || !m_i2c) begin
			i_state_reg <= I_IDLE;
			i_shift_reg <= `LHIF_BYTE_ZERO;
			i_cnt_reg <= 4'h0;
			i_ack_reg <= 1'b0;
			i_addr_ok_reg <= 1'b0;
			i_valid <= 1'b0;
		end else begin
			i_valid <= 1'b0;
			if (i_start) begin
				i_state_reg <= I_ADDR;
				i_cnt_reg <= 4'h0;
				i_ack_reg <= 1'b0;
			end else if (i_stop) begin
				i_state_reg <= I_IDLE;
				i_ack_reg <= 1'b0;
			end else begin
				case (i_state_reg)
				I_IDLE: begin
					i_ack_reg <= 1'b0;
				end
				I_ADDR, I_DATA: begin
					if (sclk_rise) begin
						i_shift_reg <= i_byte;
						i_cnt_reg <= i_cnt_reg + 4'h1;
						if (i_cnt_reg == `LHIF_I2C_CNT_LAST) begin
							if (i_state_reg == I_ADDR) begin
								i_addr_ok_reg <= (i_byte[7:3] ==
									`LHIF_I2C_ADDR_HI) &&
									(i_byte[2:1] == sa) && !i_byte[0];
							end else begin
								i_valid <= 1'b1;
							end
						end
					end
					if (i_scl_fall && i_cnt_reg == `LHIF_I2C_CNT_ACK) begin
						i_state_reg <= I_ACK;
						i_ack_reg <= (i_state_reg == I_DATA) || i_addr_ok_reg;
					end
				end
				I_ACK: begin
					if (i_scl_fall) begin
						i_ack_reg <= 1'b0;
						i_cnt_reg <= 4'h0;
						i_state_reg <= i_addr_ok_reg ? I_DATA : I_IDLE;
					end
				end
				default: begin
					i_state_reg <= I_IDLE;
				end
				endcase
			end
		end
	end
	// ----------------------------------------
	// write capture and read strobe
	// ----------------------------------------
	wire par_wr = sel && ((m_prw && wr_rise) ||
		(m_pen && !wr_n_or_rw && en_fall));
	always @(posedge core_clk) begin
		if (!rstn) begin
			write_valid <= 1'b0;
			write_data <= `LHIF_BYTE_ZERO;
			write_is_display <= 1'b0;
			read_strobe <= 1'b0;
		end else begin
			write_valid <= 1'b0;
			read_strobe <= sel && ((m_prw && prd_fall) ||
				(m_pen && wr_n_or_rw && en_rise));
			if (par_wr) begin
				write_valid <= 1'b1;
				write_data <= data_bus_in;
				write_is_display <= data_command_select;
			end else if (spi_valid) begin
				write_valid <= 1'b1;
				write_data <= spi_byte;
				write_is_display <= m_spi4 && data_command_select;
			end else if (i_valid) begin
				write_valid <= 1'b1;
				write_data <= i_shift_reg;
				write_is_display <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// data bus drive
	// ----------------------------------------
	wire rd_on = sel && ((m_pen && rd_n_or_enable && wr_n_or_rw) ||
		(m_prw && !rd_n_or_enable));
	always @(posedge core_clk) begin
		if (!rstn) begin
			data_bus_out <= `LHIF_BYTE_ZERO;
			data_bus_oe <= `LHIF_BYTE_ZERO;
		end else if (rd_on) begin
			data_bus_out <= read_data;
			data_bus_oe <= `LHIF_BUS_DRIVE;
		end else if (m_i2c && i_ack_reg) begin
			data_bus_out <= `LHIF_BYTE_ZERO;
			data_bus_oe <= `LHIF_ACK_PINS;
		end else begin
			data_bus_out <= `LHIF_BYTE_ZERO;
			data_bus_oe <= `LHIF_BYTE_ZERO;
		end
	end
	// ----------------------------------------
	// straps after reset and clock source
	// ----------------------------------------
	reg strap_taken_reg;
	always @(posedge core_clk) begin
		if (!rstn) begin
			strap_taken_reg <= 1'b0;
			booster_5x <= `LHIF_BOOST_4X;
			bias_1_9 <= `LHIF_BIAS_1_7;
			use_internal_osc <= 1'b0;
			ext_clock_level <= 1'b0;
		end else begin
			strap_taken_reg <= 1'b1;
			if (!strap_taken_reg) begin
				booster_5x <= booster_default_strap;
				bias_1_9 <= bias_default_strap;
			end
			use_internal_osc <= clock_source_pin;
			ext_clock_level <= clock_source_pin;
		end
	end
endmodule

//--- lhif_host_front_tb_top.sv
`timescale 1ns/10ps
`include "lhif_map.vh"
// ----------------------------------------
// testbench
// ----------------------------------------
module lhif_host_front_tb_top;
	reg core_clk = 1'b0;
	reg rstn = 1'b0;
	reg [2:0] mode = 3'h0;
	reg b = 1'b0;
	reg [7:0] rdat = 8'h00;
	reg [7:0] q;
	reg a1;
	reg a2;
	reg [8:0] wlast = 9'h000;
	integer wcnt = 0;
	integer n;
	integer nr;
	integer rcnt = 0;
	wire rs, bst, bia, osc, ext;
	wire [3:0] sts = {bst, bia, osc, ext};
	integer miscompares = 0;
	integer n_compared = 0;
	wire cs_n, dc, rd, wr, wv, wdisp;
	wire [7:0] hd, bus, oe, out, wd;
	wire ack = mode == `LHIF_MODE_I2C && |(oe[3:2] & ~out[3:2]);
	assign bus = ((oe & out) | (~oe & hd)) & ~{6'h00, ack, 1'b0};
	always #5 core_clk = ~core_clk;
	lhif_host_front dut_u (.core_clk(core_clk), .rstn(rstn),
		.interface_select_straps(mode), .booster_default_strap(b),
		.bias_default_strap(!b), .clock_source_pin(b),
		.chip_select_n(cs_n), .data_command_select(dc),
		.rd_n_or_enable(rd), .wr_n_or_rw(wr), .data_bus_in(bus),
		.data_bus_out(out), .data_bus_oe(oe), .read_data(rdat),
		.write_valid(wv), .write_data(wd), .write_is_display(wdisp),
		.read_strobe(rs), .booster_5x(bst), .bias_1_9(bia),
		.use_internal_osc(osc), .ext_clock_level(ext));
	lhif_host_model host_u (.core_clk(core_clk), .bus(bus), .cs_n(cs_n),
		.dc(dc), .rd(rd), .wr(wr), .d(hd));
	always @(posedge core_clk) begin
		if (wv === 1'b1) begin
			wcnt <= wcnt + 1;
			wlast <= {wdisp, wd};
		end
		if (rs === 1'b1) begin
			rcnt <= rcnt + 1;
		end
	end
	task chk(input string s, input [8:0] e, input [8:0] g);
		n_compared = n_compared + 1;
		if (g !== e) begin
			$display("[FAIL] %s exp %h got %h", s, e, g);
			miscompares = miscompares + 1;
		end
	endtask
	task rst(input [2:0] m, input s);
		rstn = 1'b0;
		mode = m;
		b = s;
		host_u.idle(m == `LHIF_MODE_PAR_EN);
		host_u.cyc(8);
		chk("reset out", 9'h000, {wv, oe});
		rstn = 1'b1;
		host_u.cyc(2);
		chk("straps", {5'h00, s, !s, s, s}, {5'h00, sts});
		n = wcnt;
		nr = rcnt;
	endtask
	task t_par(input m);
		rst(m ? `LHIF_MODE_PAR_EN : `LHIF_MODE_PAR_RW, m);
		host_u.pw(m, 1'b1, 8'hA5, 1'b1);
		chk("wr disp", {1'b1, 8'hA5}, wlast);
		host_u.pw(m, 1'b1, 8'h3C, 1'b0);
		chk("wr cmd", {1'b0, 8'h3C}, wlast);
		host_u.pw(m, 1'b0, 8'hFF, 1'b1);
		rdat = 8'h96;
		host_u.pr(m, q);
		chk("read", 9'h096, {1'b0, q});
		chk("read strobes", 9'(nr + 1), 9'(rcnt));
		chk("writes", 9'(n + 2), 9'(wcnt));
		chk("oe off", 9'h000, {1'b0, oe});
		$display("test parallel %0d done", m);
	endtask
	task t_spi;
		rst(`LHIF_MODE_SPI4, 1'b0);
		host_u.sb(3, 8'hFF);
		host_u.desel;
		host_u.sb(8, 8'h81);
		host_u.desel;
		chk("spi count", 9'(n + 1), 9'(wcnt));
		chk("spi byte", {1'b1, 8'h81}, wlast);
		rst(`LHIF_MODE_SPI3, 1'b1);
		host_u.sb(8, 8'h5A);
		host_u.desel;
		chk("spi3 byte", {1'b0, 8'h5A}, wlast);
		$display("test serial done");
	endtask
	task t_i2c;
		rst(`LHIF_MODE_I2C, 1'b0);
		host_u.ic(2'h2, {`LHIF_I2C_ADDR_HI, 3'h4, 8'hC3}, a1, a2);
		chk("acks", 9'h003, {7'h00, a1, a2});
		chk("i2c byte", {1'b0, 8'hC3}, wlast);
		n = wcnt;
		host_u.ic(2'h2, {`LHIF_I2C_ADDR_HI, 3'h2, 8'h77}, a1, a2);
		chk("nacks", 9'h000, {7'h00, a1, a2});
		chk("i2c count", 9'(n), 9'(wcnt));
		$display("test i2c done");
	endtask
	task complete_run;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#100000;
		miscompares = miscompares + 1;
		complete_run;
	end
	initial begin
		host_u.cyc(1);
		t_par(1'b0);
		t_par(1'b1);
		t_spi;
		t_i2c;
		complete_run;
	end
endmodule

//--- lhif_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// host side model
// ----------------------------------------
module lhif_host_model (
	// clock and bus wire
	input wire core_clk,
	input wire [7:0] bus,
	// host pins
	output reg cs_n = 1'b1,
	output reg dc = 1'b1,
	output reg rd = 1'b1,
	output reg wr = 1'b1,
	output reg [7:0] d = 8'hFF
);
	integer i;
	reg x;
	task cyc(input integer n);
		repeat (n) @(negedge core_clk);
	endtask
	task idle(input m);
		rd = !m;
		wr = 1'b1;
	endtask
	task pw(input m, input s, input [7:0] v, input c);
		cs_n = !s;
		dc = c;
		d = v;
		wr = 1'b0;
		rd = 1'b1;
		cyc(2);
		if (m) rd = 1'b0;
		else wr = 1'b1;
		cyc(2);
		cs_n = 1'b1;
		d = ~v;
		cyc(2);
	endtask
	task pr(input m, output [7:0] q);
		cs_n = 1'b0;
		wr = 1'b1;
		rd = m;
		cyc(3);
		q = bus;
		rd = !m;
		cyc(1);
		cs_n = 1'b1;
		cyc(2);
	endtask
	task sb(input integer n, input [7:0] v);
		cs_n = 1'b0;
		for (i = 0; i < n; i = i + 1) begin
			d[1] = v[7-i];
			cyc(2);
			d[0] = 1'b1;
			cyc(2);
			d[0] = 1'b0;
		end
		cyc(3);
	endtask
	task desel;
		cs_n = 1'b1;
		d[1] = ~d[1];
		cyc(3);
	endtask
	task ib(input b, output a);
		d[1] = b;
		cyc(2);
		d[0] = 1'b1;
		cyc(2);
		a = !bus[1];
		d[0] = 1'b0;
		cyc(2);
	endtask
	task ic(input [1:0] sa, input [15:0] v, output a1, output a2);
		d = {sa[0], sa[1], 6'h3F};
		cyc(2);
		d[1] = 1'b0;
		cyc(2);
		d[0] = 1'b0;
		for (i = 15; i >= 8; i = i - 1) ib(v[i], x);
		ib(1'b1, a1);
		for (i = 7; i >= 0; i = i - 1) ib(v[i], x);
		ib(1'b1, a2);
		d[1] = 1'b0;
		d[0] = 1'b1;
		cyc(2);
		d[1] = 1'b1;
		cyc(2);
	endtask
endmodule

//--- lhif_map.vh
`ifndef LHIF_MAP_VH
`define LHIF_MAP_VH
// ----------------------------------------
// interface mode straps (pin0,pin1,pin2)
// ----------------------------------------
`define LHIF_MODE_SPI4 3'b000
`define LHIF_MODE_SPI3 3'b001
`define LHIF_MODE_PAR_RW 3'b010
`define LHIF_MODE_PAR_EN 3'b011
`define LHIF_MODE_I2C 3'b111
// ----------------------------------------
// field positions and values
// ----------------------------------------
// pins carrying slave address bit1 and bit0
`define LHIF_SA_HI 6
`define LHIF_SA_LO 7
`define LHIF_BYTE_MSB 7
`define LHIF_BIT_CNT_LAST 3'h7
`define LHIF_BIT_CNT_ZERO 3'h0
`define LHIF_BYTE_ZERO 8'h00
`define LHIF_BOOST_4X 1'b0
`define LHIF_BOOST_5X 1'b1
`define LHIF_BIAS_1_7 1'b0
`define LHIF_BIAS_1_9 1'b1
`define LHIF_I2C_ADDR_HI 5'h1E
`define LHIF_I2C_CNT_LAST 4'h7
`define LHIF_I2C_CNT_ACK 4'h8
`define LHIF_BUS_DRIVE 8'hFF
`define LHIF_ACK_PINS 8'h0C
`endif

//--- lhif_serial_rx.v
`timescale 1ns/10ps
`include "lhif_map.vh"
module lhif_serial_rx #(
	parameter WIDTH = 8
) (
	// clock and reset
	input wire core_clk,
	input wire rstn,
	// control
	input wire active,
	input wire sclk_rise,
	input wire sdata,
	// byte out
	output reg byte_valid,
	output reg [WIDTH-1:0] byte_data
);
	reg [WIDTH-1:0] shift_reg;
	reg [2:0] cnt_reg;
	wire [WIDTH-1:0] shift_next;
	assign shift_next = {shift_reg[WIDTH-2:0], sdata};
	always @(posedge core_clk) begin
		if (!rstn || !active) begin
			shift_reg <= `LHIF_BYTE_ZERO;
			cnt_reg <= `LHIF_BIT_CNT_ZERO;
			byte_valid <= 1'b0;
		end else begin
			byte_valid <= 1'b0;
			if (sclk_rise) begin
				shift_reg <= shift_next;
				cnt_reg <= cnt_reg + 3'h1;
				if (cnt_reg == `LHIF_BIT_CNT_LAST) begin
					byte_valid <= 1'b1;
				end
			end
		end
	end
	always @(posedge core_clk) begin
		if (!rstn) begin
			byte_data <= `LHIF_BYTE_ZERO;
		end else if (active && sclk_rise && cnt_reg == `LHIF_BIT_CNT_LAST) begin
			byte_data <= shift_next;
		end
	end
endmodule
